//--- rtl/epi_irq_unit.sv
// external pin irq unit: registers, enable sync, flags, irq, nmi, events, wake
//
// Notes on behaviour
// - sense field picks edge/level, zero means off
// - cleared edge flag waits for new edge
// - cleared level flag resets while level holds
// - filter is majority of three samples
// - filter only while its enable bit set
// - unfiltered level detection needs no ticks
// - filter or edge config requests detect clock
// - latency bounded by few clocks per mode
// - nmi has own sense and filter
// - nmi ignores global enable, resets off
// - nmi flag always drives nmi line
// - enable set/clear by writing ones
// - irq while flagged and enabled pin
// - one shared irq, separate nmi line
// - per-pin event enable gates events
// - per-pin wake enable allows wake-up
// - global enable starts and stops block
// - soft reset restores all registers, disables
// - enable/reset writes set sync pending
// - writes during pending share one slot, the last wins; a parked soft reset stays
// - events are single pulses
// - soft reset write discards other bits
// - enable reads back once its write launches
`timescale 1ns/1ns
module epi_irq_unit (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [epi_pkg::EPI_AW-1:0] addr_i,
   input wire logic [epi_pkg::EPI_DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [epi_pkg::EPI_DW-1:0] rdata_o,
   input wire logic [epi_pkg::EPI_PINS-1:0] ext_irq_pin_i,
   input wire logic nmi_pin_i,
   input wire logic detect_clock_i,
   output logic irq_o,
   output logic nmi_o,
   output logic [epi_pkg::EPI_PINS-1:0] event_o,
   output logic wake_o,
   output logic detect_clk_req_o
);
   import epi_pkg::*;

   // detect clock is sampled as a plain input; its rising edge is the filter tick
   logic dck1_q;
   logic dck2_q;
   logic dck3_q;
   wire logic tick;

   logic ctrl_en_q;
   logic en_act_q;
   logic pend_soft_reset_q;
   epi_sync_e sy_q;
   logic [1:0] cnt_q;
   logic def_v_q;
   logic def_en_q;
   logic def_soft_reset_q;
   logic [3:0] nmi_ctrl_q;
   logic nmi_flag_q;
   logic [15:0] evt_en_q;
   logic [15:0] inten_q;
   logic [15:0] flags_q;
   logic [15:0] wake_en_q;
   logic [63:0] cfg_q;
   logic [15:0] match_prev_q;
   logic [31:0] rdata_q;
   logic irq_q;
   logic nmi_q;
   logic [15:0] event_q;
   logic wake_q;
   logic clk_req_q;

   wire logic [15:0] pin_match;
   wire logic nmi_match;
   wire logic [16:0] pin_clk_need;
   wire logic wr_ctrl;
   wire logic busy;
   wire logic done;
   wire logic srst_done;
   wire logic launch_new;
   wire logic launch_def;
   wire logic launch;
   wire logic lw_en;
   wire logic lw_soft_reset;
   wire logic [15:0] wd16;
   wire logic wr_nmi_ctrl;
   wire logic wr_nmi_flag;
   wire logic wr_evt;
   wire logic wr_clr;
   wire logic wr_set;
   wire logic wr_flags;
   wire logic wr_wake;
   wire logic wr_cfg0;
   wire logic wr_cfg1;
   wire logic [31:0] rd_mux;
   wire logic [15:0] flags_d;
   wire logic nmi_flag_d;
   wire logic [15:0] inten_base;

   assign tick = dck2_q & ~dck3_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dck1_q <= 1'b0;
         dck2_q <= 1'b0;
         dck3_q <= 1'b0;
      end else begin
         dck1_q <= detect_clock_i;
         dck2_q <= dck1_q;
         dck3_q <= dck2_q;
      end
   end

   // pin detectors
   genvar gi;
   generate
      for (gi = 0; gi < EPI_PINS; gi++) begin : g_pin
         epi_pin_detect u_det (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .pin_i(ext_irq_pin_i[gi]),
            .tick_i(tick),
            .cfg_i(cfg_q[CFG_FIELD_W*gi +: CFG_FIELD_W]),
            .active_i(en_act_q),
            .match_o(pin_match[gi])
         );
         assign pin_clk_need[gi] = epi_needs_clk(cfg_q[CFG_FIELD_W*gi +: CFG_FIELD_W]);
      end
   endgenerate

   // nmi runs on its own sense and filter fields alone, whatever the global enable says
   epi_pin_detect u_nmi_det (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(nmi_pin_i),
      .tick_i(tick),
      .cfg_i(nmi_ctrl_q),
      .active_i(1'b1),
      .match_o(nmi_match)
   );
   assign pin_clk_need[16] = epi_needs_clk(nmi_ctrl_q);

   // address decode
   assign wd16 = wdata_i[15:0];
   assign wr_ctrl = wr_i & (addr_i == OFS_CTRL);
   assign wr_nmi_ctrl = wr_i & (addr_i == OFS_NMI_CTRL);
   assign wr_nmi_flag = wr_i & (addr_i == OFS_NMI_FLAG);
   assign wr_evt = wr_i & (addr_i == OFS_EVT_CTRL);
   assign wr_clr = wr_i & (addr_i == OFS_EN_CLR);
   assign wr_set = wr_i & (addr_i == OFS_EN_SET);
   assign wr_flags = wr_i & (addr_i == OFS_FLAGS);
   assign wr_wake = wr_i & (addr_i == OFS_WAKE);
   assign wr_cfg0 = wr_i & (addr_i == OFS_CFG0);
   assign wr_cfg1 = wr_i & (addr_i == OFS_CFG1);

   // enable / soft reset handshake; the port cannot stall, so a write that
   // lands while busy is parked and launched when the current one ends
   assign busy = (sy_q == SY_BUSY);
   assign done = busy & (cnt_q == 2'h0);
   assign srst_done = done & pend_soft_reset_q;
   // a write parked in the finishing cycle launches from idle one cycle on
   assign launch_def = def_v_q & (done | ~busy);
   assign launch_new = wr_ctrl & ~busy & ~def_v_q;
   assign launch = launch_new | launch_def;
   assign lw_soft_reset = launch_def ? def_soft_reset_q : wdata_i[CTRL_SOFT_RESET_BIT];
   assign lw_en = launch_def ? def_en_q : wdata_i[CTRL_EN_BIT];

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sy_q <= SY_IDLE;
         cnt_q <= 2'h0;
      end else begin
         unique case (sy_q)
            SY_IDLE: begin
               if (launch) begin
                  sy_q <= SY_BUSY;
                  cnt_q <= SYNC_CYCLES - 2'h1;
               end
            end
            SY_BUSY: begin
               if (launch) begin
                  cnt_q <= SYNC_CYCLES - 2'h1;
               end else if (done) begin
                  sy_q <= SY_IDLE;
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         def_v_q <= 1'b0;
         def_en_q <= 1'b0;
         def_soft_reset_q <= 1'b0;
      end else if (wr_ctrl & (busy | def_v_q)) begin
         // a parked soft reset is never overwritten by a later enable write
         def_v_q <= 1'b1;
         def_en_q <= wdata_i[CTRL_EN_BIT] & ~wdata_i[CTRL_SOFT_RESET_BIT];
         def_soft_reset_q <= (def_v_q & ~launch_def & def_soft_reset_q) | wdata_i[CTRL_SOFT_RESET_BIT];
      end else if (launch_def) begin
         def_v_q <= 1'b0;
         def_soft_reset_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_en_q <= 1'b0;
         en_act_q <= 1'b0;
         pend_soft_reset_q <= 1'b0;
      end else begin
         if (srst_done) begin
            ctrl_en_q <= 1'b0;
         end
         if (done) begin
            en_act_q <= pend_soft_reset_q ? 1'b0 : ctrl_en_q;
         end
         if (launch) begin
            pend_soft_reset_q <= lw_soft_reset;
            if (!lw_soft_reset) begin
               ctrl_en_q <= lw_en;
            end
         end
      end
   end

   // a write in the soft reset finishing cycle lands on the reset value
   assign inten_base = srst_done ? RST_PIN_VEC : inten_q;

   // configuration registers; soft reset completion returns them to reset
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         nmi_ctrl_q <= RST_NMI_CTRL;
         evt_en_q <= RST_PIN_VEC;
         inten_q <= RST_PIN_VEC;
         wake_en_q <= RST_PIN_VEC;
         cfg_q <= {RST_CFG_WORD, RST_CFG_WORD};
      end else begin
         if (srst_done) begin
            nmi_ctrl_q <= RST_NMI_CTRL;
            evt_en_q <= RST_PIN_VEC;
            inten_q <= RST_PIN_VEC;
            wake_en_q <= RST_PIN_VEC;
            cfg_q <= {RST_CFG_WORD, RST_CFG_WORD};
         end
         if (wr_nmi_ctrl) begin
            nmi_ctrl_q <= wdata_i[3:0];
         end
         if (wr_evt) begin
            evt_en_q <= wd16;
         end
         if (wr_set) begin
            inten_q <= inten_base | wd16;
         end
         if (wr_clr) begin
            inten_q <= inten_base & ~wd16;
         end
         if (wr_wake) begin
            wake_en_q <= wd16;
         end
         if (wr_cfg0) begin
            cfg_q[31:0] <= wdata_i;
         end
         if (wr_cfg1) begin
            cfg_q[63:32] <= wdata_i;
         end
      end
   end

   // flags: a detection in the clearing cycle wins over the clear
   assign flags_d = srst_done ? RST_PIN_VEC
                  : ((flags_q & ~(wr_flags ? wd16 : 16'h0000)) | pin_match);
   assign nmi_flag_d = srst_done ? 1'b0
                     : ((nmi_flag_q & ~(wr_nmi_flag & wdata_i[0])) | nmi_match);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flags_q <= RST_PIN_VEC;
         nmi_flag_q <= 1'b0;
         match_prev_q <= RST_PIN_VEC;
      end else begin
         flags_q <= flags_d;
         nmi_flag_q <= nmi_flag_d;
         match_prev_q <= pin_match;
      end
   end

   // outputs, all registered
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_q <= 1'b0;
         nmi_q <= 1'b0;
         event_q <= RST_PIN_VEC;
         wake_q <= 1'b0;
         clk_req_q <= 1'b0;
      end else begin
         irq_q <= |(flags_q & inten_q);
         nmi_q <= nmi_flag_q;
         // level matches hold for many cycles, so only the rising match is sent
         event_q <= pin_match & ~match_prev_q & evt_en_q;
         wake_q <= |(pin_match & wake_en_q);
         clk_req_q <= |pin_clk_need;
      end
   end

   // read mux; unmapped addresses read zero
   assign rd_mux =
      (addr_i == OFS_CTRL) ? {30'h0, ctrl_en_q, (busy & pend_soft_reset_q) | (def_v_q & def_soft_reset_q)} :
      (addr_i == OFS_STATUS) ? {24'h0, busy | def_v_q, 7'h00} :
      (addr_i == OFS_NMI_CTRL) ? {28'h0, nmi_ctrl_q} :
      (addr_i == OFS_NMI_FLAG) ? {31'h0, nmi_flag_q} :
      (addr_i == OFS_EVT_CTRL) ? {16'h0, evt_en_q} :
      (addr_i == OFS_EN_CLR) ? {16'h0, inten_q} :
      (addr_i == OFS_EN_SET) ? {16'h0, inten_q} :
      (addr_i == OFS_FLAGS) ? {16'h0, flags_q} :
      (addr_i == OFS_WAKE) ? {16'h0, wake_en_q} :
      (addr_i == OFS_CFG0) ? cfg_q[31:0] :
      (addr_i == OFS_CFG1) ? cfg_q[63:32] : 32'h0;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= rd_i ? rd_mux : 32'h0;
      end
   end

   assign rdata_o = rdata_q;
   assign irq_o = irq_q;
   assign nmi_o = nmi_q;
   assign event_o = event_q;
   assign wake_o = wake_q;
   assign detect_clk_req_o = clk_req_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_nmi_line;
      nmi_flag_q |=> nmi_o;
   endproperty
   a_nmi_line: assert property (p_nmi_line) else $error("nmi line low with flag set");

   property p_nmi_set;
      nmi_match && !srst_done |=> nmi_flag_q;
   endproperty
   a_nmi_set: assert property (p_nmi_set) else $error("nmi flag not set");

   property p_irq_on;
      (flags_q & inten_q) != 16'h0 |=> irq_o;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq not raised");

   property p_irq_off;
      (flags_q & inten_q) == 16'h0 |=> !irq_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq raised without cause");

   property p_flag_set;
      pin_match != 16'h0 && !srst_done |=> (flags_q & $past(pin_match)) == $past(pin_match);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("pin flag not set on match");

   property p_en_clr;
      wr_clr && !wr_set |=> (inten_q & $past(wd16)) == 16'h0;
   endproperty
   a_en_clr: assert property (p_en_clr) else $error("enable clear failed");

   property p_sync_set;
      launch_new |=> busy ##1 busy;
   endproperty
   a_sync_set: assert property (p_sync_set) else $error("sync pending not held");

   property p_readback;
      launch_new && !wdata_i[CTRL_SOFT_RESET_BIT] |=> ctrl_en_q == $past(wdata_i[CTRL_EN_BIT]);
   endproperty
   a_readback: assert property (p_readback) else $error("enable readback wrong");

   property p_soft_reset_prio;
      launch_new && wdata_i[CTRL_SOFT_RESET_BIT] |=> pend_soft_reset_q && ctrl_en_q == $past(ctrl_en_q);
   endproperty
   a_soft_reset_prio: assert property (p_soft_reset_prio) else $error("soft reset did not win");

   property p_srst_clear;
      srst_done && !wr_i |=> inten_q == 16'h0 && nmi_ctrl_q == 4'h0 && !en_act_q;
   endproperty
   a_srst_clear: assert property (p_srst_clear) else $error("soft reset left state");

   property p_evt_pulse;
      event_q != 16'h0 |=> (event_q & $past(event_q)) == 16'h0;
   endproperty
   a_evt_pulse: assert property (p_evt_pulse) else $error("event held over two cycles");

   property p_clk_req;
      pin_clk_need != 17'h0 |=> detect_clk_req_o;
   endproperty
   a_clk_req: assert property (p_clk_req) else $error("detect clock not requested");
endmodule

//--- rtl/epi_pkg.sv
// shared constants, types and decode helpers for the external pin irq unit
package epi_pkg;
   localparam int EPI_PINS = 16;
   localparam int EPI_AW = 8;
   localparam int EPI_DW = 32;

   // printed offsets, used as byte addresses on the plain port
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h01;
   localparam logic [7:0] OFS_NMI_CTRL = 8'h02;
   localparam logic [7:0] OFS_NMI_FLAG = 8'h03;
   localparam logic [7:0] OFS_EVT_CTRL = 8'h04;
   localparam logic [7:0] OFS_EN_CLR = 8'h08;
   localparam logic [7:0] OFS_EN_SET = 8'h0c;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_WAKE = 8'h14;
   localparam logic [7:0] OFS_CFG0 = 8'h18;
   localparam logic [7:0] OFS_CFG1 = 8'h1c;

   // field positions
   localparam int CTRL_SOFT_RESET_BIT = 0;
   localparam int CTRL_EN_BIT = 1;
   localparam int STATUS_BUSY_BIT = 7;
   localparam int CFG_FIELD_W = 4;
   localparam int CFG_FILT_BIT = 3;

   // reset values
   localparam logic [15:0] RST_PIN_VEC = 16'h0000;
   localparam logic [31:0] RST_CFG_WORD = 32'h0000_0000;
   localparam logic [3:0] RST_NMI_CTRL = 4'h0;

   // cycles the enable/soft reset handshake takes to settle
   localparam logic [1:0] SYNC_CYCLES = 2'h3;

   // sense encodings
   localparam logic [2:0] SENSE_NONE = 3'h0;
   localparam logic [2:0] SENSE_RISE = 3'h1;
   localparam logic [2:0] SENSE_FALL = 3'h2;
   localparam logic [2:0] SENSE_BOTH = 3'h3;
   localparam logic [2:0] SENSE_HIGH = 3'h4;
   localparam logic [2:0] SENSE_LOW = 3'h5;

   typedef struct packed {
      logic filt;
      logic [2:0] sense;
   } epi_pin_cfg_s;

   typedef enum logic [1:0] {
      SY_IDLE = 2'b01,
      SY_BUSY = 2'b10
   } epi_sync_e;

   function automatic logic epi_sense_hit(input logic [2:0] sense, input logic val,
                                          input logic prev);
      unique case (sense)
         SENSE_RISE: epi_sense_hit = val & ~prev;
         SENSE_FALL: epi_sense_hit = ~val & prev;
         SENSE_BOTH: epi_sense_hit = val ^ prev;
         SENSE_HIGH: epi_sense_hit = val;
         SENSE_LOW: epi_sense_hit = ~val;
         default: epi_sense_hit = 1'b0;
      endcase
   endfunction

   // filter or edge sensing needs the detect clock running
   function automatic logic epi_needs_clk(input epi_pin_cfg_s c);
      epi_needs_clk = c.filt | (c.sense inside {SENSE_RISE, SENSE_FALL, SENSE_BOTH});
   endfunction
endpackage

//--- rtl/epi_pin_detect.sv
// one pin: synchroniser, majority filter and sense match
`timescale 1ns/1ns
module epi_pin_detect (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic pin_i,
   input wire logic tick_i,
   input epi_pkg::epi_pin_cfg_s cfg_i,
   input wire logic active_i,
   output logic match_o
);
   import epi_pkg::*;

   logic sync1_q;
   logic sync2_q;
   logic [2:0] samp_q;
   logic prev_q;
   wire logic maj;
   wire logic val;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         samp_q <= 3'h0;
         prev_q <= 1'b0;
      end else begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
         if (tick_i) begin
            samp_q <= {samp_q[1:0], sync2_q};
         end
         prev_q <= val;
      end
   end

   assign maj = (samp_q[0] & samp_q[1]) | (samp_q[0] & samp_q[2]) | (samp_q[1] & samp_q[2]);
   assign val = cfg_i.filt ? maj : sync2_q;
   // edges only fire on a change of val, so a cleared edge flag waits for a new edge
   assign match_o = active_i & epi_sense_hit(cfg_i.sense, val, prev_q);

   property p_samp_shift;
      @(posedge clk_i) disable iff (!rst_b_i)
      tick_i |=> samp_q[0] == $past(sync2_q) && samp_q[2:1] == $past(samp_q[1:0]);
   endproperty
   a_samp_shift: assert property (p_samp_shift) else $error("filter sample not shifted");
endmodule

//--- bench/epi_far_model.sv
// far side model: external pin drivers and detect clock source
`timescale 1ns/1ns
module epi_far_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic req_i,
   input wire logic [15:0] pins_i,
   input wire logic nmi_i,
   output logic [15:0] pins_o,
   output logic nmi_o,
   output logic dclk_o
);
   logic [1:0] div_q;
   // pins are driven levels, never released, so no float handling
   assign pins_o = pins_i;
   assign nmi_o = nmi_i;
   // detect clock runs only while requested, slow on purpose
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_q <= 2'h0;
      end else if (req_i) begin
         div_q <= div_q + 2'h1;
      end else begin
         div_q <= 2'h0;
      end
   end
   assign dclk_o = div_q[1];
endmodule

//--- bench/epi_irq_unit_tb_top.sv
// self-checking bench for the external pin irq unit
`timescale 1ns/1ns
module epi_irq_unit_tb_top;
   import epi_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [15:0] pin_set = 16'h0;
   logic nmi_set = 1'b0;
   logic [15:0] pins;
   logic nmi_pin;
   logic dclk;
   logic irq_o, nmi_o, wake_o, req_o;
   logic [15:0] event_o;
   logic [31:0] rv;
   int fail_count = 0;
   int n_checks = 0;
   int ev_cnt = 0;
   logic [7:0] regs [9] = '{OFS_CTRL, OFS_NMI_CTRL, OFS_NMI_FLAG, OFS_EVT_CTRL, OFS_EN_SET,
                            OFS_FLAGS, OFS_WAKE, OFS_CFG0, OFS_CFG1};

   always #25 clk_i = ~clk_i;

   epi_far_model u_epi_far_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_o),
      .pins_i(pin_set), .nmi_i(nmi_set), .pins_o(pins), .nmi_o(nmi_pin), .dclk_o(dclk));

   epi_irq_unit u_epi_irq_unit (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_irq_pin_i(pins),
      .nmi_pin_i(nmi_pin), .detect_clock_i(dclk), .irq_o(irq_o), .nmi_o(nmi_o),
      .event_o(event_o), .wake_o(wake_o), .detect_clk_req_o(req_o));

   // count cycles with the pin 1 event high, a pulse gives exactly one
   always @(posedge clk_i) begin
      if (event_o[1] === 1'b1) ev_cnt++;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a, rv);
      chk(rv, exp);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 20; i++) begin
         rd(OFS_STATUS, rv);
         if (rv[STATUS_BUSY_BIT] === 1'b0) return;
      end
      chk(32'h1, 32'h0);
      end_sim();
   endtask

   // bounded wait for an output, a miss counts as a mismatch
   task automatic wait_hi(ref logic s, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         #1;
         if (s === 1'b1) return;
      end
      chk(32'h0, 32'h1);
      end_sim();
   endtask

   task automatic all_zero();
      foreach (regs[i]) rdchk(regs[i], 32'h0);
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      all_zero();
      rdchk(8'h40, 32'h0);
      $display("test reset values done");

      // config before enable, as software must
      wr(OFS_CFG0, 32'h0000_0094);
      wr(OFS_EVT_CTRL, 32'h2);
      wr(OFS_WAKE, 32'h1);
      wr(OFS_EN_SET, 32'h3);
      wr(OFS_EN_SET, 32'h0);
      rdchk(OFS_EN_CLR, 32'h3);
      wr(OFS_CTRL, 32'h2);
      wr(OFS_CTRL, 32'h2);
      rdchk(OFS_STATUS, 32'h80);
      rdchk(OFS_CTRL, 32'h2);
      wait_idle();
      chk({31'h0, req_o}, 32'h1);
      $display("test enable done");

      pin_set[0] <= 1'b1;
      wait_hi(irq_o, 4);
      rdchk(OFS_FLAGS, 32'h1);
      chk({31'h0, wake_o}, 32'h1);
      wr(OFS_FLAGS, 32'h1);
      rdchk(OFS_FLAGS, 32'h1);
      pin_set[0] <= 1'b0;
      repeat (4) @(posedge clk_i);
      wr(OFS_FLAGS, 32'h1);
      rdchk(OFS_FLAGS, 32'h0);
      #1;
      chk({31'h0, irq_o}, 32'h0);
      $display("test level done");

      ev_cnt = 0;
      pin_set[1] <= 1'b1;
      wait_hi(irq_o, 27);
      rdchk(OFS_FLAGS, 32'h2);
      repeat (8) @(posedge clk_i);
      chk(ev_cnt, 32'h1);
      wr(OFS_FLAGS, 32'h2);
      repeat (40) @(posedge clk_i);
      rdchk(OFS_FLAGS, 32'h0);
      wr(OFS_EN_CLR, 32'h2);
      rdchk(OFS_EN_SET, 32'h1);
      $display("test edge done");

      // pin2 fall, pin3 both, pin4 low; pin4 low level matches at once
      wr(OFS_CFG0, 32'h0005_3290);
      rdchk(OFS_FLAGS, 32'h10);
      pin_set[3:2] <= 2'h3;
      repeat (4) @(posedge clk_i);
      rdchk(OFS_FLAGS, 32'h18);
      wr(OFS_FLAGS, 32'h8);
      pin_set[3:2] <= 2'h0;
      repeat (4) @(posedge clk_i);
      rdchk(OFS_FLAGS, 32'h1c);
      $display("test sense modes done");

      // nmi works with the block disabled
      wr(OFS_CTRL, 32'h0);
      wait_idle();
      wr(OFS_NMI_CTRL, {28'h0, 1'b0, SENSE_HIGH});
      nmi_set <= 1'b1;
      wait_hi(nmi_o, 8);
      rdchk(OFS_NMI_FLAG, 32'h1);
      nmi_set <= 1'b0;
      repeat (4) @(posedge clk_i);
      wr(OFS_NMI_FLAG, 32'h1);
      rdchk(OFS_NMI_FLAG, 32'h0);
      chk({31'h0, nmi_o}, 32'h0);
      $display("test nmi done");

      wr(OFS_CTRL, 32'h3);
      rd(OFS_CTRL, rv);
      chk(rv, 32'h1);
      wait_idle();
      all_zero();
      chk({31'h0, req_o}, 32'h0);
      $display("test soft reset done");
      end_sim();
   end
endmodule
